// *** hdl/psc_defines.svh ***
`ifndef PSC_DEFINES_SVH
`define PSC_DEFINES_SVH

`define PSC_NCORES        4
`define PSC_NRANKS        4
`define PSC_AW            8

`define PSC_ADDR_CTRL     8'h00
`define PSC_ADDR_CORE_REQ 8'h04
`define PSC_ADDR_TUNE     8'h08
`define PSC_ADDR_STATUS   8'h0C
`define PSC_ADDR_CORE_STA 8'h10

`define PSC_CTRL_RESET    32'h0000_1800
`define PSC_CORE_RESET    32'h0000_0000
`define PSC_TUNE_RESET    32'h0000_0210

`define PSC_CTRL_SYS_LSB  0
`define PSC_CTRL_PDM_LSB  4
`define PSC_CTRL_SR_REQ   6
`define PSC_CTRL_SR_DLL   7
`define PSC_CTRL_SR_PLL   8
`define PSC_CTRL_TRM_OFF  9
`define PSC_CTRL_CLK_STOP 10
`define PSC_CTRL_LR_EN    11
`define PSC_CTRL_DR_EN    12
`define PSC_CTRL_FAST_EX  13
`define PSC_CTRL_LFP_REL  14

`define PSC_CODE_C0       4'h0
`define PSC_CODE_C1       4'h1
`define PSC_CODE_C1E      4'h2
`define PSC_CODE_C3       4'h3
`define PSC_CODE_C6       4'h6
`define PSC_CODE_C7       4'h7

`define PSC_SYS_S0        3'h0
`define PSC_SYS_S3        3'h1
`define PSC_SYS_S4        3'h2
`define PSC_SYS_S5        3'h3
`define PSC_SYS_G3        3'h4

`define PSC_EXIT_CMD_CYC  5'h05
`define PSC_EXIT_DATA_CYC 5'h10

`define PSC_RESP_OKAY     2'h0
`define PSC_RESP_SLVERR   2'h2

`endif

// *** hdl/psc_pkg.sv ***
package psc_pkg;

	typedef enum logic [2:0] {
		core_active_state,
		core_halt_state,
		core_halt_low_freq_state,
		core_state_3,
		core_state_6,
		core_state_7
	} core_state_t;

	typedef enum logic [1:0] {
		pkg_active,
		pkg_snoopable_idle,
		pkg_light_retention,
		pkg_deeper_retention
	} pkg_state_t;

	typedef enum logic [2:0] {
		sys_on,
		sys_ctx_save,
		sys_suspend_mem,
		sys_suspend_disk,
		sys_soft_off,
		sys_mech_off
	} sys_state_t;

	typedef enum logic [1:0] {
		rank_active,
		rank_powerdown,
		rank_exit,
		rank_self_refresh
	} rank_state_t;

	typedef enum logic [2:0] {
		v_nominal,
		v_lowest_freq,
		v_minimum,
		v_retention,
		v_gated
	} vreq_t;

	typedef enum logic [1:0] {
		active_powerdown,
		precharge_pd_fast_exit,
		precharge_pd_slow_exit,
		register_powerdown
	} pd_mode_t;

endpackage

// *** hdl/power_state_controller.sv ***
// Function
// RQ1: Full-on runs normally; suspend-to-memory saves context to memory before power-off.
// RQ2: Suspend-to-disk and soft-off keep only wake logic; soft-off reboots; mech-off none.
// RQ3: Package idle entered only when every core is at least its minimum state.
// RQ4: Package idle sets ring voltage, PLL and cache; cache never fully flushed.
// RQ5: Package idle state 7 never resolved; deeper retention is the deepest.
// RQ6: Leaving any package idle returns package to the lowest frequency point.
// RQ7: Retention package actions selectable from exit-latency targets given to controller.
// RQ8: Core states 3 and 6 request a configured level below minimum voltage; the code requests it for state 3 only, state 6 gets v_gated.
// RQ9: Per-core clock, PLL, flush, voltage and gating follow each core idle state.
// RQ10: Normal memory operation keeps CKE asserted to every rank.
// RQ11: CKE power-down per rank after idle time; active power-down by default.
// RQ12: Active power-down drops CKE and waits exit latency before commands.
// RQ13: Fast-exit precharge power-down drops CKE, DLL stays on, same exit wait.
// RQ14: Slow-exit precharge power-down turns DLL off; 16 cycles before first data.
// RQ15: Register power-down drops both CKEs; terminations on or off by mode.
// RQ16: Self-refresh drops CKE and allows no memory transactions.
// RQ17: Self-refresh entry and exit apply to all channels together.
// RQ18: Option turns the I/O master delay loop off in self-refresh.
// RQ19: Option turns the memory controller PLL off in self-refresh.
// RQ20: Registered DIMMs get clock-stopped power-down with termination on or off.
// RQ21: Each core returns to active before moving between idle states.
// RQ22: Package state re-evaluated on every core change; exits at once on activity.
`timescale 1ns/100ps
`include "psc_defines.svh"
`default_nettype none

module power_state_controller
	import psc_pkg::*;
(
	input  wire logic                         core_clk_i,
	input  wire logic                         rst_n_i,
	input  wire logic                         ce_i,
	input  wire logic [`PSC_AW-1:0]           s_axi_awaddr_i,
	input  wire logic                         s_axi_awvalid_i,
	output logic                              s_axi_awready_o,
	input  wire logic [31:0]                  s_axi_wdata_i,
	input  wire logic [3:0]                   s_axi_wstrb_i,
	input  wire logic                         s_axi_wvalid_i,
	output logic                              s_axi_wready_o,
	output logic [1:0]                        s_axi_bresp_o,
	output logic                              s_axi_bvalid_o,
	input  wire logic                         s_axi_bready_i,
	input  wire logic [`PSC_AW-1:0]           s_axi_araddr_i,
	input  wire logic                         s_axi_arvalid_i,
	output logic                              s_axi_arready_o,
	output logic [31:0]                       s_axi_rdata_o,
	output logic [1:0]                        s_axi_rresp_o,
	output logic                              s_axi_rvalid_o,
	input  wire logic                         s_axi_rready_i,
	input  wire logic                         ctx_saved_i,
	input  wire logic [`PSC_NRANKS-1:0]       rank_busy_i,
	output logic                              main_pwr_en_o,
	output logic                              wake_pwr_en_o,
	output logic                              ctx_save_o,
	output logic                              reboot_o,
	output logic [2:0]                        ring_vreq_o,
	output logic                              ring_pll_on_o,
	output logic                              ring_min_freq_o,
	output logic                              llc_flush_o,
	output logic                              lowest_frequency_point_o,
	output logic [`PSC_NCORES-1:0]            core_clk_run_o,
	output logic [`PSC_NCORES-1:0]            core_pll_on_o,
	output logic [`PSC_NCORES-1:0]            core_cache_flush_o,
	output logic [`PSC_NCORES-1:0]            core_ctx_flush_o,
	output logic [`PSC_NCORES-1:0]            core_pgate_o,
	output logic [3*`PSC_NCORES-1:0]          core_vreq_o,
	output logic [3:0]                        core_vret_level_o,
	output logic [`PSC_NRANKS-1:0]            cke_o,
	output logic [1:0]                        reg_cke_o,
	output logic [`PSC_NRANKS-1:0]            rank_dll_off_o,
	output logic [`PSC_NRANKS-1:0]            cmd_ok_o,
	output logic [`PSC_NRANKS-1:0]            data_ok_o,
	output logic                              input_buffer_termination_o,
	output logic                              reg_clk_stop_o,
	output logic                              sr_active_o,
	output logic                              io_master_delay_loop_off_o,
	output logic                              mc_pll_off_o
);

	function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction

	function automatic core_state_t dec_core(input logic [3:0] f);
		case (f)
			`PSC_CODE_C1:  dec_core = core_halt_state;
			`PSC_CODE_C1E: dec_core = core_halt_low_freq_state;
			`PSC_CODE_C3:  dec_core = core_state_3;
			`PSC_CODE_C6:  dec_core = core_state_6;
			`PSC_CODE_C7:  dec_core = core_state_7;
			default:       dec_core = core_active_state;
		endcase
	endfunction

	function automatic logic [3:0] enc_core(input core_state_t s);
		case (s)
			core_halt_state:          enc_core = `PSC_CODE_C1;
			core_halt_low_freq_state: enc_core = `PSC_CODE_C1E;
			core_state_3:             enc_core = `PSC_CODE_C3;
			core_state_6:             enc_core = `PSC_CODE_C6;
			core_state_7:             enc_core = `PSC_CODE_C7;
			default:                  enc_core = `PSC_CODE_C0;
		endcase
	endfunction

	logic [31:0]        ctrl_q;
	logic [31:0]        core_req_q;
	logic [31:0]        tune_q;
	logic [`PSC_AW-1:0] aw_addr_q;
	logic [31:0]        w_data_q;
	logic [3:0]         w_strb_q;
	logic               aw_full_q;
	logic               w_full_q;
	logic               wr_fire;
	logic               wr_hit;
	logic [31:0]        rd_mux;
	logic               rd_hit;
	core_state_t        core_q [`PSC_NCORES];
	pkg_state_t         pkg_q;
	pkg_state_t         pkg_d;
	sys_state_t         sys_q;
	rank_state_t        rank_q [`PSC_NRANKS];
	logic [7:0]         idle_cnt_q [`PSC_NRANKS];
	logic [4:0]         exit_cnt_q [`PSC_NRANKS];
	logic               sr_go;
	logic               all_ge3;
	logic               all_ge6;
	logic               lfp_q;
	pd_mode_t           pd_mode;

	assign pd_mode = pd_mode_t'(ctrl_q[`PSC_CTRL_PDM_LSB +: 2]);
	assign wr_fire = aw_full_q && w_full_q && !s_axi_bvalid_o;
	assign wr_hit  = (aw_addr_q == `PSC_ADDR_CTRL) || (aw_addr_q == `PSC_ADDR_CORE_REQ)
		|| (aw_addr_q == `PSC_ADDR_TUNE);

	// Bus slave: address and data are taken in either order, one write in flight
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			aw_full_q       <= 1'b0;
			w_full_q        <= 1'b0;
			aw_addr_q       <= '0;
			w_data_q        <= '0;
			w_strb_q        <= '0;
			s_axi_awready_o <= 1'b1;
			s_axi_wready_o  <= 1'b1;
			s_axi_bvalid_o  <= 1'b0;
			s_axi_bresp_o   <= `PSC_RESP_OKAY;
		end else if (ce_i) begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_addr_q       <= s_axi_awaddr_i;
				aw_full_q       <= 1'b1;
				s_axi_awready_o <= 1'b0;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_data_q       <= s_axi_wdata_i;
				w_strb_q       <= s_axi_wstrb_i;
				w_full_q       <= 1'b1;
				s_axi_wready_o <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid_o <= 1'b1;
				s_axi_bresp_o  <= wr_hit ? `PSC_RESP_OKAY : `PSC_RESP_SLVERR;
			end
			if (s_axi_bvalid_o && s_axi_bready_i) begin
				s_axi_bvalid_o  <= 1'b0;
				aw_full_q       <= 1'b0;
				w_full_q        <= 1'b0;
				s_axi_awready_o <= 1'b1;
				s_axi_wready_o  <= 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			ctrl_q     <= `PSC_CTRL_RESET;
			core_req_q <= `PSC_CORE_RESET;
			tune_q     <= `PSC_TUNE_RESET;
		end else if (ce_i && wr_fire) begin
			case (aw_addr_q)
				`PSC_ADDR_CTRL:     ctrl_q <= merge_strb(ctrl_q, w_data_q, w_strb_q);
				`PSC_ADDR_CORE_REQ: core_req_q <= merge_strb(core_req_q, w_data_q, w_strb_q);
				`PSC_ADDR_TUNE:     tune_q <= merge_strb(tune_q, w_data_q, w_strb_q);
				default: ;
			endcase
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		case (s_axi_araddr_i)
			`PSC_ADDR_CTRL:     rd_mux = ctrl_q;
			`PSC_ADDR_CORE_REQ: rd_mux = core_req_q;
			`PSC_ADDR_TUNE:     rd_mux = tune_q;
			`PSC_ADDR_STATUS: begin
				rd_mux[2:0]  = sys_q;
				rd_mux[5:4]  = pkg_q;
				rd_mux[6]    = sr_active_o;
				rd_mux[7]    = lfp_q;
				rd_mux[11:8] = cke_o;
			end
			`PSC_ADDR_CORE_STA: begin
				for (int c = 0; c < `PSC_NCORES; c++) begin
					rd_mux[4*c +: 4] = enc_core(core_q[c]);
				end
			end
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			s_axi_arready_o <= 1'b1;
			s_axi_rvalid_o  <= 1'b0;
			s_axi_rdata_o   <= 32'h0000_0000;
			s_axi_rresp_o   <= `PSC_RESP_OKAY;
		end else if (ce_i) begin
			if (s_axi_arvalid_i && s_axi_arready_o) begin
				s_axi_arready_o <= 1'b0;
				s_axi_rvalid_o  <= 1'b1;
				s_axi_rdata_o   <= rd_mux;
				s_axi_rresp_o   <= rd_hit ? `PSC_RESP_OKAY : `PSC_RESP_SLVERR;
			end else if (s_axi_rvalid_o && s_axi_rready_i) begin
				s_axi_rvalid_o  <= 1'b0;
				s_axi_arready_o <= 1'b1;
			end
		end
	end

	// System sleep states
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			sys_q    <= sys_on;
			reboot_o <= 1'b0;
		end else if (ce_i) begin
			reboot_o <= 1'b0;
			case (sys_q)
				sys_on: begin
					case (ctrl_q[`PSC_CTRL_SYS_LSB +: 3])
						`PSC_SYS_S3: sys_q <= sys_ctx_save;             // see RQ1
						`PSC_SYS_S4: sys_q <= sys_suspend_disk;         // see RQ2
						`PSC_SYS_S5: sys_q <= sys_soft_off;             // see RQ2
						`PSC_SYS_G3: sys_q <= sys_mech_off;             // see RQ2
						default:     sys_q <= sys_on;
					endcase
				end
				// Power stays until memory holds the context
				sys_ctx_save: if (ctx_saved_i) begin
					sys_q <= sys_suspend_mem;                           // see RQ1
				end
				sys_suspend_mem: if (ctrl_q[`PSC_CTRL_SYS_LSB +: 3] == `PSC_SYS_S0) begin
					sys_q <= sys_on;
				end
				default: if (ctrl_q[`PSC_CTRL_SYS_LSB +: 3] == `PSC_SYS_S0) begin
					sys_q    <= sys_on;
					reboot_o <= 1'b1;                                   // see RQ2
				end
			endcase
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			main_pwr_en_o <= 1'b1;
			wake_pwr_en_o <= 1'b1;
			ctx_save_o    <= 1'b0;
		end else if (ce_i) begin
			main_pwr_en_o <= (sys_q == sys_on) || (sys_q == sys_ctx_save); // see RQ1
			wake_pwr_en_o <= (sys_q != sys_mech_off);                      // see RQ2
			ctx_save_o    <= (sys_q == sys_ctx_save);                      // see RQ1
		end
	end

	// Core idle states: any move between two idle states passes through active
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			for (int c = 0; c < `PSC_NCORES; c++) begin
				core_q[c] <= core_active_state;
			end
		end else if (ce_i) begin
			for (int c = 0; c < `PSC_NCORES; c++) begin
				if (core_q[c] == core_active_state) begin
					core_q[c] <= dec_core(core_req_q[4*c +: 4]);
				end else if (dec_core(core_req_q[4*c +: 4]) != core_q[c]) begin
					core_q[c] <= core_active_state;                     // see RQ21
				end
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			core_clk_run_o     <= '1;
			core_pll_on_o      <= '1;
			core_cache_flush_o <= '0;
			core_ctx_flush_o   <= '0;
			core_pgate_o       <= '0;
			core_vreq_o        <= '0;
			core_vret_level_o  <= 4'h0;
		end else if (ce_i) begin
			core_vret_level_o <= tune_q[11:8];                          // see RQ8
			for (int c = 0; c < `PSC_NCORES; c++) begin
				core_clk_run_o[c]     <= (core_q[c] == core_active_state);  // see RQ9
				core_pll_on_o[c]      <= (core_q[c] < core_state_6);        // see RQ9
				core_cache_flush_o[c] <= (core_q[c] >= core_state_3);       // see RQ9
				core_ctx_flush_o[c]   <= (core_q[c] >= core_state_6);       // see RQ9
				core_pgate_o[c]       <= (core_q[c] >= core_state_6);       // see RQ9
				case (core_q[c])
					core_halt_low_freq_state: core_vreq_o[3*c +: 3] <= v_lowest_freq;
					core_state_3:             core_vreq_o[3*c +: 3] <= v_retention; // see RQ8
					core_state_6,
					core_state_7:             core_vreq_o[3*c +: 3] <= v_gated;
					default:                  core_vreq_o[3*c +: 3] <= v_nominal;
				endcase
			end
		end
	end

	// Package resolution from the present core states, every cycle
	always_comb begin
		all_ge3 = 1'b1;
		all_ge6 = 1'b1;
		for (int c = 0; c < `PSC_NCORES; c++) begin
			if (core_q[c] < core_state_3) all_ge3 = 1'b0;                  // see RQ3
			if (core_q[c] < core_state_6) all_ge6 = 1'b0;                  // see RQ3
		end
		// A tight exit-latency target keeps the PLL running in snoopable idle
		if (all_ge6 && ctrl_q[`PSC_CTRL_DR_EN] && !ctrl_q[`PSC_CTRL_FAST_EX]) begin
			pkg_d = pkg_deeper_retention;                               // see RQ5
		end else if (all_ge3 && ctrl_q[`PSC_CTRL_LR_EN] && !ctrl_q[`PSC_CTRL_FAST_EX]) begin
			pkg_d = pkg_light_retention;                                // see RQ7
		end else if (all_ge3) begin
			pkg_d = pkg_snoopable_idle;
		end else begin
			pkg_d = pkg_active;                                         // see RQ22
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			pkg_q <= pkg_active;
		end else if (ce_i) begin
			pkg_q <= pkg_d;                                             // see RQ22
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			ring_vreq_o     <= v_nominal;
			ring_pll_on_o   <= 1'b1;
			ring_min_freq_o <= 1'b0;
			llc_flush_o     <= 1'b0;
		end else if (ce_i) begin
			llc_flush_o <= 1'b0;                                        // see RQ4
			case (pkg_q)
				pkg_snoopable_idle: begin
					ring_vreq_o     <= v_minimum;                       // see RQ4
					ring_pll_on_o   <= 1'b1;
					ring_min_freq_o <= 1'b1;
				end
				pkg_light_retention,
				pkg_deeper_retention: begin
					ring_vreq_o     <= v_retention;                     // see RQ4
					ring_pll_on_o   <= 1'b0;
					ring_min_freq_o <= 1'b1;
				end
				default: begin
					ring_vreq_o     <= v_nominal;
					ring_pll_on_o   <= 1'b1;
					ring_min_freq_o <= 1'b0;
				end
			endcase
		end
	end

	// Resume point is held until software releases it; a new resume wins
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			lfp_q                    <= 1'b0;
			lowest_frequency_point_o <= 1'b0;
		end else if (ce_i) begin
			if (pkg_q != pkg_active && pkg_d == pkg_active) begin
				lfp_q <= 1'b1;                                          // see RQ6
			end else if (wr_fire && aw_addr_q == `PSC_ADDR_CTRL && w_strb_q[1]
				&& w_data_q[`PSC_CTRL_LFP_REL]) begin
				lfp_q <= 1'b0;
			end
			lowest_frequency_point_o <= lfp_q;
		end
	end

	// Memory ranks; self-refresh is one decision for every channel
	assign sr_go = ctrl_q[`PSC_CTRL_SR_REQ] || (sys_q == sys_suspend_mem)
		|| (sys_q == sys_ctx_save && ctx_saved_i);                     // see RQ17

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			for (int r = 0; r < `PSC_NRANKS; r++) begin
				rank_q[r]     <= rank_active;
				idle_cnt_q[r] <= 8'h00;
				exit_cnt_q[r] <= 5'h00;
			end
		end else if (ce_i) begin
			for (int r = 0; r < `PSC_NRANKS; r++) begin
				case (rank_q[r])
					rank_active: begin
						exit_cnt_q[r] <= 5'h00;
						if (sr_go) begin
							rank_q[r] <= rank_self_refresh;             // see RQ16
						end else if (rank_busy_i[r]) begin
							idle_cnt_q[r] <= 8'h00;
						end else if (idle_cnt_q[r] >= tune_q[7:0]) begin
							rank_q[r] <= rank_powerdown;                // see RQ11
						end else begin
							idle_cnt_q[r] <= idle_cnt_q[r] + 8'h01;
						end
					end
					rank_powerdown: begin
						idle_cnt_q[r] <= 8'h00;
						if (sr_go) begin
							rank_q[r] <= rank_self_refresh;
						end else if (rank_busy_i[r]) begin
							rank_q[r] <= rank_exit;
						end
					end
					rank_exit: begin
						exit_cnt_q[r] <= exit_cnt_q[r] + 5'h01;
						if (exit_cnt_q[r] >= `PSC_EXIT_DATA_CYC
							|| (pd_mode != precharge_pd_slow_exit
							&& exit_cnt_q[r] >= `PSC_EXIT_CMD_CYC)) begin
							rank_q[r] <= rank_active;                   // see RQ14
						end
					end
					default: if (!sr_go) begin
						rank_q[r]     <= rank_exit;                     // see RQ17
						exit_cnt_q[r] <= 5'h00;
					end
				endcase
			end
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			cke_o          <= '1;
			reg_cke_o      <= 2'b11;
			rank_dll_off_o <= '0;
			cmd_ok_o       <= '1;
			data_ok_o      <= '1;
		end else if (ce_i) begin
			for (int r = 0; r < `PSC_NRANKS; r++) begin
				cke_o[r] <= (rank_q[r] == rank_active)
					|| (rank_q[r] == rank_exit);                        // see RQ10
				rank_dll_off_o[r] <= (rank_q[r] == rank_powerdown
					&& pd_mode == precharge_pd_slow_exit);              // see RQ13
				cmd_ok_o[r] <= (rank_q[r] == rank_active)
					|| (rank_q[r] == rank_exit
					&& exit_cnt_q[r] >= `PSC_EXIT_CMD_CYC);             // see RQ12
				data_ok_o[r] <= (rank_q[r] == rank_active);
			end
			reg_cke_o <= (pd_mode == register_powerdown
				&& rank_q[0] == rank_powerdown) ? 2'b00 : 2'b11;        // see RQ15
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			input_buffer_termination_o <= 1'b1;
			reg_clk_stop_o             <= 1'b0;
			sr_active_o                <= 1'b0;
			io_master_delay_loop_off_o <= 1'b0;
			mc_pll_off_o               <= 1'b0;
		end else if (ce_i) begin
			input_buffer_termination_o <= !(pd_mode == register_powerdown
				&& rank_q[0] == rank_powerdown && ctrl_q[`PSC_CTRL_TRM_OFF]); // see RQ15
			reg_clk_stop_o <= ctrl_q[`PSC_CTRL_CLK_STOP]
				&& pd_mode == register_powerdown
				&& rank_q[0] == rank_powerdown;                         // see RQ20
			sr_active_o <= (rank_q[0] == rank_self_refresh);
			io_master_delay_loop_off_o <= (rank_q[0] == rank_self_refresh)
				&& ctrl_q[`PSC_CTRL_SR_DLL];                            // see RQ18
			mc_pll_off_o <= (rank_q[0] == rank_self_refresh)
				&& ctrl_q[`PSC_CTRL_SR_PLL];                            // see RQ19
		end
	end

endmodule

`default_nettype wire

// *** tb/power_state_controller_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none
module psc_checker
	import psc_pkg::*;
(
	input wire logic       core_clk_i,
	input wire logic       rst_n_i,
	input wire logic       llc_flush_o,
	input wire logic       sr_active_o,
	input wire logic       io_master_delay_loop_off_o,
	input wire logic       mc_pll_off_o,
	input wire logic       ring_min_freq_o,
	input wire logic       ring_pll_on_o,
	input wire logic       main_pwr_en_o,
	input wire logic       wake_pwr_en_o,
	input wire logic [2:0] ring_vreq_o,
	input wire logic [3:0] cke_o,
	input wire logic [3:0] cmd_ok_o,
	input wire logic [3:0] data_ok_o,
	input wire logic [3:0] core_pgate_o,
	input wire logic [3:0] core_pll_on_o,
	input wire logic [3:0] core_clk_run_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	AST_LLC_KEPT: assert property (!llc_flush_o) else $error("llc flushed");
	AST_RING_SNOOP: assert property (ring_min_freq_o |-> ring_vreq_o == (ring_pll_on_o ? v_minimum : v_retention))
		else $error("snoopable idle ring wrong");
	AST_SR_QUIET: assert property (sr_active_o |-> cke_o == 4'h0 && cmd_ok_o == 4'h0)
		else $error("self refresh not quiet");
	AST_CMD_WAIT: assert property ($rose(cke_o[0]) |-> !cmd_ok_o[0] [*3])
		else $error("command too soon");
	AST_CMD_CKE: assert property (cmd_ok_o[0] |-> cke_o[0]) else $error("command with cke low");
	AST_DATA_CMD: assert property (data_ok_o[0] |-> cmd_ok_o[0]) else $error("data before command");
	AST_SR_OPTS: assert property ((io_master_delay_loop_off_o || mc_pll_off_o) |-> sr_active_o)
		else $error("option off outside self refresh");
	AST_GATE: assert property (core_pgate_o[0] |-> !core_pll_on_o[0] && !core_clk_run_o[0])
		else $error("gated core running");
	AST_POWER: assert property (!wake_pwr_en_o |-> !main_pwr_en_o) else $error("main on in off");
	cover property (sr_active_o);
	cover property ($fell(cke_o[0]));
	cover property (core_pgate_o[0]);
endmodule
bind power_state_controller psc_checker chk_u (.*);
`default_nettype wire

// *** tb/rank_traffic_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module rank_traffic_model (
	input  wire logic       clk_i,
	input  wire logic       rst_n_i,
	input  wire logic [3:0] want_i,
	input  wire logic [3:0] cke_i,
	input  wire logic [3:0] cmd_ok_i,
	output logic      [3:0] busy_o,
	output int              bad_o
);
	// Pending traffic is a level; a rank never refuses it
	always_ff @(posedge clk_i) begin
		busy_o <= rst_n_i ? want_i : 4'h0;
	end
	// Counted, not fatal, so the bench reports every slip
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			bad_o <= 0;
		end else if (|(cmd_ok_i & ~cke_i)) begin
			bad_o <= bad_o + 1;
		end
	end
endmodule
`default_nettype wire

// *** tb/test_power_state_controller.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_power_state_controller;
	logic        core_clk_i = 0, rst_n_i = 0, ce_i = 1, ctx_saved_i = 0;
	logic        s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0;
	logic        s_axi_arvalid_i = 0, s_axi_rready_i = 0;
	logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
	logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rd;
	logic [3:0]  s_axi_wstrb_i = 4'hF, want = 4'h0, rank_busy_i;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, reg_cke_o, rs;
	logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
	logic        s_axi_arready_o, s_axi_rvalid_o, main_pwr_en_o, wake_pwr_en_o;
	logic        ctx_save_o, reboot_o, ring_pll_on_o, ring_min_freq_o, llc_flush_o;
	logic        lowest_frequency_point_o, input_buffer_termination_o, reg_clk_stop_o;
	logic        sr_active_o, io_master_delay_loop_off_o, mc_pll_off_o;
	logic [2:0]  ring_vreq_o;
	logic [3:0]  core_clk_run_o, core_pll_on_o, core_cache_flush_o, core_ctx_flush_o;
	logic [3:0]  core_pgate_o, core_vret_level_o, cke_o, rank_dll_off_o, cmd_ok_o, data_ok_o;
	logic [11:0] core_vreq_o;
	int          err_total = 0, checked = 0, i, bad;
	always #50 core_clk_i = ~core_clk_i;
	power_state_controller dut_u (.*);
	rank_traffic_model rank_u (.clk_i(core_clk_i), .rst_n_i(rst_n_i), .want_i(want),
		.cke_i(cke_o), .cmd_ok_i(cmd_ok_o), .busy_o(rank_busy_i), .bad_o(bad));
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit ad, wd;
		@(posedge core_clk_i);
		{s_axi_awaddr_i, s_axi_wdata_i} <= {a, d};
		{s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i} <= 3'h7;
		while (!(ad && wd)) begin
			@(posedge core_clk_i);
			if (s_axi_awready_o && !ad) s_axi_awvalid_i <= 0;
			if (s_axi_wready_o && !wd) s_axi_wvalid_i <= 0;
			ad |= s_axi_awready_o;
			wd |= s_axi_wready_o;
		end
		while (s_axi_bvalid_o !== 1'b1) @(posedge core_clk_i);
		s_axi_bready_i <= 0;
	endtask
	task automatic rdt(input logic [7:0] a);
		@(posedge core_clk_i);
		{s_axi_araddr_i, s_axi_arvalid_i, s_axi_rready_i} <= {a, 2'h3};
		do @(posedge core_clk_i); while (s_axi_arready_o !== 1'b1);
		s_axi_arvalid_i <= 0;
		do @(posedge core_clk_i); while (s_axi_rvalid_o !== 1'b1);
		{rd, rs} = {s_axi_rdata_o, s_axi_rresp_o};
		s_axi_rready_i <= 0;
	endtask
	task automatic t_reset();
		chk("cke", 4'hF, cke_o);
		rdt(8'h00);
		chk("ctrl", 32'h0000_1800, rd);
		rdt(8'h20);
		chk("resp", 2'h2, rs);
	endtask
	task automatic t_rank();
		wr(8'h08, 32'h0000_0208);
		for (i = 0; i < 400 && cke_o !== 4'h0; i++) @(posedge core_clk_i);
		chk("cke idle", 4'h0, cke_o);
		want <= 4'h1;
		for (i = 0; i < 400 && cke_o[0] !== 1'b1; i++) @(posedge core_clk_i);
		for (i = 0; i < 400 && cmd_ok_o[0] !== 1'b1; i++) @(posedge core_clk_i);
		chk("exit gap", 1'b1, i >= 3 && i <= 5);
		want <= 4'h0;
	endtask
	task automatic t_slow();
		wr(8'h00, 32'h0000_1820);
		for (i = 0; i < 400 && cke_o[0] !== 1'b0; i++) @(posedge core_clk_i);
		chk("dll off", 1'b1, rank_dll_off_o[0]);
		want <= 4'h1;
		for (i = 0; i < 400 && cke_o[0] !== 1'b1; i++) @(posedge core_clk_i);
		for (i = 0; i < 400 && data_ok_o[0] !== 1'b1; i++) @(posedge core_clk_i);
		chk("data gap", 1'b1, i >= 16);
		want <= 4'h0;
	endtask
	task automatic t_sr();
		wr(8'h00, 32'h0000_1BF0);
		for (i = 0; i < 400 && sr_active_o !== 1'b1; i++) @(posedge core_clk_i);
		chk("sr cke", 6'h03, {cke_o, reg_cke_o});
		chk("sr opts", 2'h3, {io_master_delay_loop_off_o, mc_pll_off_o});
		wr(8'h00, 32'h0000_1E30);
		for (i = 0; i < 400 && reg_cke_o !== 2'h0; i++) @(posedge core_clk_i);
		chk("sr off", 5'h01, {io_master_delay_loop_off_o, mc_pll_off_o,
			reg_cke_o, input_buffer_termination_o, reg_clk_stop_o});
	endtask
	task automatic t_core();
		wr(8'h04, 32'h0000_6666);
		for (i = 0; i < 400 && ring_pll_on_o !== 1'b0; i++) @(posedge core_clk_i);
		chk("pll", 4'h0, core_pll_on_o);
		rdt(8'h0C);
		chk("pkg", 2'h3, rd[5:4]);
		wr(8'h04, 32'h0000_6660);
		for (i = 0; i < 400 && lowest_frequency_point_o !== 1'b1; i++) @(posedge core_clk_i);
		rdt(8'h0C);
		chk("pkg exit", 3'h1, {rd[5:4], lowest_frequency_point_o});
	endtask
	task automatic t_sys();
		wr(8'h00, 32'h0000_1801);
		for (i = 0; i < 400 && ctx_save_o !== 1'b1; i++) @(posedge core_clk_i);
		chk("main on", 1'b1, main_pwr_en_o);
		ctx_saved_i <= 1;
		for (i = 0; i < 400 && main_pwr_en_o !== 1'b0; i++) @(posedge core_clk_i);
		chk("s3 sr", 1'b1, sr_active_o);
		wr(8'h00, 32'h0);
		wr(8'h00, 32'h0000_1804);
		for (i = 0; i < 400 && wake_pwr_en_o !== 1'b0; i++) @(posedge core_clk_i);
		chk("g3", 2'h0, {wake_pwr_en_o, main_pwr_en_o});
	endtask
	task automatic final_report();
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge core_clk_i);
		rst_n_i <= 1;
		t_reset();
		t_rank();
		t_slow();
		t_sr();
		t_core();
		t_sys();
		chk("model", 0, bad);
		final_report();
	end
	initial begin
		repeat (20000) @(posedge core_clk_i);
		err_total++;
		final_report();
	end
endmodule
`default_nettype wire
